// File: inc/ucc_pkg.sv
package ucc_pkg;

    // register addresses (byte addresses on the 16-bit special function space)
    localparam logic [15:0] ADDR_USB_OSC_MODE = 16'hFFA5;
    localparam logic [15:0] ADDR_PLL_CONTROL = 16'hFFA6;
    localparam logic [15:0] ADDR_USB_CLOCK_GATE = 16'hFFA7;

    // reset values, and the value read from an unmapped address
    localparam logic [7:0] RST_USB_OSC_MODE = 8'h00;
    localparam logic [7:0] RST_PLL_CONTROL = 8'h00;
    localparam logic [7:0] RST_USB_CLOCK_GATE = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // field positions
    localparam int BIT_USB_OSC_HALT = 0;
    localparam int BIT_PLL_HALT = 0;
    localparam int BIT_PLL_RATIO_SELECT = 1;
    localparam int BIT_USB_GATE_ENABLE = 7;

    // pll multiplication ratios and input pre-divide
    localparam logic [3:0] PLL_MULT_X8 = 4'h8;
    localparam logic [3:0] PLL_MULT_X12 = 4'hC;
    localparam logic [2:0] PLL_PREDIV_1 = 3'h1;
    localparam logic [2:0] PLL_PREDIV_2 = 3'h2;
    localparam logic [2:0] PLL_PREDIV_4 = 3'h4;

    // start-up: cycles from reset release until the cpu is released
    localparam logic [1:0] BOOT_CYCLES = 2'h2;

    // prescaler depth: fxp, /2, /4, /8, /16
    localparam int CPU_DIV_STAGES = 5;

    typedef struct packed {
        logic run;          // pll oscillating
        logic src_hs;       // 1: high-speed system clock, 0: dedicated 6 MHz osc
        logic [2:0] prediv; // input divide applied before the pll
        logic [3:0] mult;   // multiplication ratio
    } ucc_pll_cfg_t;

    typedef enum logic [1:0] {
        UCC_BOOT = 2'b01,
        UCC_RUN = 2'b10
    } ucc_state_t;

endpackage

// File: core/ucc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ucc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    generate
        if (WIDTH < 1) begin : g_bad
            $error("ucc_sync: WIDTH must be at least 1");
        end
    endgenerate

    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            q <= '0;
        end else if (ce) begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule
`default_nettype wire

// File: core/ucc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module ucc_prescaler #(
    parameter int DIV_STAGES = 5
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic enable,
    input wire logic main_tick,
    input wire logic [2:0] sel,
    output logic [DIV_STAGES-1:0] div_tick,
    output logic cpu_tick
);
    generate
        if (DIV_STAGES < 1 || DIV_STAGES > 8) begin : g_bad
            $error("ucc_prescaler: DIV_STAGES must be 1..8");
        end
    endgenerate

    logic [DIV_STAGES-1:0] cnt;
    logic [DIV_STAGES-1:0] next_div;
    logic next_cpu;

    // stage k fires on every 2**k-th main tick
    genvar k;
    generate
        for (k = 0; k < DIV_STAGES; k++) begin : g_div
            if (k == 0) begin : g_first
                assign next_div[k] = enable && main_tick;
            end else begin : g_rest
                assign next_div[k] = enable && main_tick && (&cnt[k-1:0]);
            end
        end
    endgenerate

    // out-of-range select falls back to the slowest stage, never a stall
    assign next_cpu = (int'(sel) < DIV_STAGES) ? next_div[sel] : next_div[DIV_STAGES-1];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
            div_tick <= '0;
            cpu_tick <= 1'b0;
        end else if (ce) begin
            if (enable && main_tick) begin
                cnt <= cnt + 1'b1;
            end
            div_tick <= next_div;
            cpu_tick <= next_cpu;
        end
    end
endmodule
`default_nettype wire

// File: core/ucc_clock_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ucc_clock_ctrl (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic HIGH_SPEED_SOURCE_SELECT,
    input wire logic MAIN_ON_HS,
    input wire logic [2:0] CPU_DIV_SEL,
    input wire logic HS_OSC_TICK,
    input wire logic XH_TICK,
    input wire logic LS_OSC_TICK,
    input wire logic HS_STOP_REQ,
    input wire logic LS_STOP_REQ,
    input wire logic LS_STOPPABLE,
    input wire logic WDT_OPTION,
    input wire logic PLL_LOCK,
    output logic USB_OSC_EN,
    output ucc_pkg::ucc_pll_cfg_t PLL_CFG,
    output logic USB_CLK_ON,
    output logic HS_OSC_EN,
    output logic LS_OSC_EN,
    output logic CPU_RUN,
    output logic CPU_TICK,
    output logic [ucc_pkg::CPU_DIV_STAGES-1:0] DIV_TICK,
    output logic PRS_TICK,
    output logic WDT_TICK,
    output logic TMR_LS_TICK
);

    ////////////////////////////////////////////////////////////////////////////
    // register port decode

    function automatic logic [1:0] reg_index(input logic [15:0] a);
        if (a == ucc_pkg::ADDR_USB_OSC_MODE) begin
            reg_index = 2'h1;
        end else if (a == ucc_pkg::ADDR_PLL_CONTROL) begin
            reg_index = 2'h2;
        end else if (a == ucc_pkg::ADDR_USB_CLOCK_GATE) begin
            reg_index = 2'h3;
        end else begin
            reg_index = 2'h0;
        end
    endfunction

    logic usb_osc_halt;
    logic pll_halt;
    logic pll_ratio_select;
    logic usb_gate_enable;

    wire logic [1:0] wr_index = WR ? reg_index(ADDR) : 2'h0;
    wire logic [1:0] rd_index = reg_index(ADDR);
    wire logic wr_usb_osc = (wr_index == 2'h1);
    wire logic wr_pll = (wr_index == 2'h2);
    wire logic wr_gate = (wr_index == 2'h3);

    wire logic [7:0] rd_usb_osc = {7'h00, usb_osc_halt};
    wire logic [7:0] rd_pll = {6'h00, pll_ratio_select, pll_halt};
    wire logic [7:0] rd_gate = {usb_gate_enable, 7'h00};
    wire logic [7:0] next_rdata = (rd_index == 2'h1) ? rd_usb_osc :
                                  (rd_index == 2'h2) ? rd_pll :
                                  (rd_index == 2'h3) ? rd_gate : ucc_pkg::READ_UNMAPPED;

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            usb_osc_halt <= ucc_pkg::RST_USB_OSC_MODE[ucc_pkg::BIT_USB_OSC_HALT];
            pll_halt <= ucc_pkg::RST_PLL_CONTROL[ucc_pkg::BIT_PLL_HALT];
            pll_ratio_select <= ucc_pkg::RST_PLL_CONTROL[ucc_pkg::BIT_PLL_RATIO_SELECT];
            usb_gate_enable <= ucc_pkg::RST_USB_CLOCK_GATE[ucc_pkg::BIT_USB_GATE_ENABLE];
            RDATA <= 8'h00;
        end else if (CE) begin
            if (wr_usb_osc) begin
                usb_osc_halt <= WDATA[ucc_pkg::BIT_USB_OSC_HALT];
            end
            if (wr_pll) begin
                pll_halt <= WDATA[ucc_pkg::BIT_PLL_HALT];
                pll_ratio_select <= WDATA[ucc_pkg::BIT_PLL_RATIO_SELECT];
            end
            if (wr_gate) begin
                usb_gate_enable <= WDATA[ucc_pkg::BIT_USB_GATE_ENABLE];
            end
            if (RD) begin
                RDATA <= next_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // start-up: hs oscillator is on from reset, cpu released without x1 wait

    ucc_pkg::ucc_state_t state;
    ucc_pkg::ucc_state_t next_state;
    logic [1:0] boot_cnt;

    always_comb begin
        next_state = state;
        case (state)
            ucc_pkg::UCC_BOOT: begin
                if (boot_cnt == ucc_pkg::BOOT_CYCLES - 2'h1) begin
                    next_state = ucc_pkg::UCC_RUN;
                end
            end
            ucc_pkg::UCC_RUN: begin
                next_state = ucc_pkg::UCC_RUN;
            end
            default: begin
                next_state = ucc_pkg::UCC_BOOT;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            state <= ucc_pkg::UCC_BOOT;
            boot_cnt <= 2'h0;
        end else if (CE) begin
            state <= next_state;
            if (state == ucc_pkg::UCC_BOOT) begin
                boot_cnt <= boot_cnt + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pll source and ratio

    logic pll_lock_s;

    ucc_sync #(
        .WIDTH(1)
    ) u_lock_sync (
        .clk(REF_CLK),
        .rst(RESET),
        .ce(CE),
        .d(PLL_LOCK),
        .q(pll_lock_s)
    );

    // the forbidden select/ratio pair keeps the pll stopped rather than guessing a ratio
    wire logic pll_forbidden = !HIGH_SPEED_SOURCE_SELECT && pll_ratio_select;
    wire logic next_pll_run = !pll_halt && !pll_forbidden;
    wire logic [2:0] next_prediv = !HIGH_SPEED_SOURCE_SELECT ? ucc_pkg::PLL_PREDIV_1 :
                                   pll_ratio_select ? ucc_pkg::PLL_PREDIV_4 :
                                   ucc_pkg::PLL_PREDIV_2;
    wire logic [3:0] next_mult = pll_ratio_select ? ucc_pkg::PLL_MULT_X12 :
                                 ucc_pkg::PLL_MULT_X8;

    // the gate is registered and needs a locked, running pll, so no runt pulse reaches usb
    wire logic next_usb_clk_on = usb_gate_enable && PLL_CFG.run && pll_lock_s;

    ////////////////////////////////////////////////////////////////////////////
    // oscillator enables and cpu / peripheral clocks

    wire logic cpu_on_hs = HIGH_SPEED_SOURCE_SELECT && MAIN_ON_HS;
    // only the two main clocks reach the cpu path; ls and 6 MHz are not wired here
    wire logic main_tick = cpu_on_hs ? XH_TICK : HS_OSC_TICK;
    // the hs oscillator cannot be stopped while it still clocks the cpu
    wire logic next_hs_en = (state == ucc_pkg::UCC_BOOT) || !(HS_STOP_REQ && cpu_on_hs);
    wire logic next_ls_en = !(LS_STOPPABLE && LS_STOP_REQ);
    wire logic next_wdt_tick = next_ls_en && WDT_OPTION && LS_OSC_TICK;
    wire logic next_tmr_tick = next_ls_en && LS_OSC_TICK;

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            PLL_CFG <= '0;
            USB_CLK_ON <= 1'b0;
            USB_OSC_EN <= 1'b1;
            HS_OSC_EN <= 1'b1;
            LS_OSC_EN <= 1'b1;
            CPU_RUN <= 1'b0;
            PRS_TICK <= 1'b0;
            WDT_TICK <= 1'b0;
            TMR_LS_TICK <= 1'b0;
        end else if (CE) begin
            PLL_CFG.run <= next_pll_run;
            PLL_CFG.src_hs <= HIGH_SPEED_SOURCE_SELECT;
            PLL_CFG.prediv <= next_prediv;
            PLL_CFG.mult <= next_mult;
            USB_CLK_ON <= next_usb_clk_on;
            USB_OSC_EN <= !usb_osc_halt;
            HS_OSC_EN <= next_hs_en;
            LS_OSC_EN <= next_ls_en;
            CPU_RUN <= (next_state == ucc_pkg::UCC_RUN);
            PRS_TICK <= main_tick;
            WDT_TICK <= next_wdt_tick;
            TMR_LS_TICK <= next_tmr_tick;
        end
    end

    ucc_prescaler #(
        .DIV_STAGES(ucc_pkg::CPU_DIV_STAGES)
    ) u_prescaler (
        .clk(REF_CLK),
        .rst(RESET),
        .ce(CE),
        .enable(CPU_RUN),
        .main_tick(main_tick),
        .sel(CPU_DIV_SEL),
        .div_tick(DIV_TICK),
        .cpu_tick(CPU_TICK)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic [2:0] since_reset;
    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            since_reset <= 3'h0;
        end else if (CE && since_reset != 3'h7) begin
            since_reset <= since_reset + 3'h1;
        end
    end

    usb_osc_write_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        (CE && WR && ADDR == ucc_pkg::ADDR_USB_OSC_MODE) ##1 CE
        |=> (USB_OSC_EN == !$past(WDATA[0], 2)))
        else $error("usb oscillator enable does not follow halt bit");

    pll_halt_write_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        (CE && WR && ADDR == ucc_pkg::ADDR_PLL_CONTROL && WDATA[0]) ##1 CE
        |=> !PLL_CFG.run)
        else $error("pll keeps running after halt written");

    pll_ratio_map_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        (CE && $past(CE) && PLL_CFG.run)
        |-> (PLL_CFG.mult == ($past(pll_ratio_select) ? 4'hC : 4'h8)
             && PLL_CFG.src_hs == $past(HIGH_SPEED_SOURCE_SELECT)))
        else $error("pll ratio does not match select bits");

    usb_48m_pair_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        PLL_CFG.run |-> ((PLL_CFG.prediv == 3'h1 && PLL_CFG.mult == 4'h8)
                      || (PLL_CFG.prediv == 3'h2 && PLL_CFG.mult == 4'h8)
                      || (PLL_CFG.prediv == 3'h4 && PLL_CFG.mult == 4'hC)))
        else $error("pll divide and ratio do not give 48 MHz");

    usb_gate_off_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        (CE && WR && ADDR == ucc_pkg::ADDR_USB_CLOCK_GATE && !WDATA[7]) ##1 CE
        |=> !USB_CLK_ON)
        else $error("usb clock still supplied after gate cleared");

    cpu_boot_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        (since_reset >= 3'h2 && since_reset != 3'h7 && CE) |-> ##[0:1] CPU_RUN)
        else $error("cpu not released shortly after reset");

    ls_always_on_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        (CE && !LS_STOPPABLE) |=> (LS_OSC_EN || !$past(CE)))
        else $error("low-speed oscillator stopped while option forbids it");

    wdt_source_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        WDT_TICK |-> ($past(WDT_OPTION) && $past(LS_OSC_TICK)))
        else $error("watchdog tick without enabled low-speed source");

    usb_glitch_free_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        $rose(USB_CLK_ON) |-> ($past(usb_gate_enable) && $past(pll_lock_s) && $past(PLL_CFG.run)))
        else $error("usb clock opened without locked pll and gate");

    cpu_stays_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        CPU_RUN |=> CPU_RUN)
        else $error("cpu clock release withdrawn");

    hs_keep_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        (CE && !(HIGH_SPEED_SOURCE_SELECT && MAIN_ON_HS)) |=> HS_OSC_EN)
        else $error("hs oscillator stopped while it clocks the cpu");

    pll_refused_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        (CE && !HIGH_SPEED_SOURCE_SELECT && pll_ratio_select) |=> !PLL_CFG.run)
        else $error("pll runs on the prohibited source and ratio pair");

    // a frozen tick is not a new one, so only judge ticks launched with ce high
    prs_source_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        (PRS_TICK && $past(CE)) |-> $past(HS_OSC_TICK || XH_TICK))
        else $error("peripheral tick from a source other than the main clocks");

    usb_on_c: cover property (@(posedge REF_CLK) disable iff (RESET) $rose(USB_CLK_ON));
    pll_div4_c: cover property (@(posedge REF_CLK) disable iff (RESET)
        PLL_CFG.run && PLL_CFG.prediv == 3'h4);
    ls_stop_c: cover property (@(posedge REF_CLK) disable iff (RESET) $fell(LS_OSC_EN));
    cpu_run_c: cover property (@(posedge REF_CLK) disable iff (RESET) $rose(CPU_RUN));
    pll_refused_c: cover property (@(posedge REF_CLK) disable iff (RESET)
        CE && !HIGH_SPEED_SOURCE_SELECT && pll_ratio_select);

endmodule
`default_nettype wire

// File: verification/ucc_pll_partner.sv
`timescale 1ns/1ps
`default_nettype none
module ucc_pll_partner #(
    parameter int LOCK_DELAY = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire ucc_pkg::ucc_pll_cfg_t pll_cfg,
    output logic pll_lock
);
    int count;
    ////////////////////////////////////////////////////////////////////////////////
    // lock drops at once when the pll stops, so a stale lock never reopens the gate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 0;
            pll_lock <= 1'b0;
        end else if (!pll_cfg.run) begin
            count <= 0;
            pll_lock <= 1'b0;
        end else if (count < LOCK_DELAY) begin
            count <= count + 1;
        end else begin
            pll_lock <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk, reset, wr, rd, hs_sel, main_on_hs, hs_tick, xh_tick, ls_tick, ce;
    logic hs_stop_req, ls_stop_req, ls_stoppable, wdt_option, pll_lock, usb_osc_en;
    logic usb_clk_on, hs_osc_en, ls_osc_en, cpu_run, cpu_tick, prs_tick, wdt_tick, tmr_tick;
    logic [15:0] addr;
    logic [7:0] wdata, rdata;
    logic [2:0] div_sel;
    logic [4:0] div_tick;
    ucc_pkg::ucc_pll_cfg_t pll_cfg;
    int mismatches, n_compared;

    ucc_clock_ctrl uut (.REF_CLK(ref_clk), .RESET(reset), .CE(ce), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .HIGH_SPEED_SOURCE_SELECT(hs_sel),
        .MAIN_ON_HS(main_on_hs), .CPU_DIV_SEL(div_sel), .HS_OSC_TICK(hs_tick),
        .XH_TICK(xh_tick), .LS_OSC_TICK(ls_tick), .HS_STOP_REQ(hs_stop_req),
        .LS_STOP_REQ(ls_stop_req), .LS_STOPPABLE(ls_stoppable), .WDT_OPTION(wdt_option),
        .PLL_LOCK(pll_lock), .USB_OSC_EN(usb_osc_en), .PLL_CFG(pll_cfg),
        .USB_CLK_ON(usb_clk_on), .HS_OSC_EN(hs_osc_en), .LS_OSC_EN(ls_osc_en),
        .CPU_RUN(cpu_run), .CPU_TICK(cpu_tick), .DIV_TICK(div_tick), .PRS_TICK(prs_tick),
        .WDT_TICK(wdt_tick), .TMR_LS_TICK(tmr_tick));
    ucc_pll_partner partner (.clk(ref_clk), .rst(reset), .pll_cfg(pll_cfg),
        .pll_lock(pll_lock));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (mismatches == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
        step(1);
    endtask
    task automatic rd_check(input logic [15:0] a, input logic [7:0] exp);
        addr = a;
        rd = 1'b1;
        step(1);
        check(16'(rdata), 16'(exp));
        rd = 1'b0;
        step(1);
    endtask
    // bounded wait; running out counts a mismatch and ends the run
    task automatic wait_sig(input logic on_gate, input logic exp, input int limit);
        int n;
        n = 0;
        while ((on_gate ? usb_clk_on : cpu_run) !== exp && n < limit) begin
            step(1);
            n++;
        end
        check(16'(on_gate ? usb_clk_on : cpu_run), 16'(exp));
        if ((on_gate ? usb_clk_on : cpu_run) !== exp) summarize();
    endtask
    task automatic pulse(input logic [2:0] t);
        step(1);
        {xh_tick, ls_tick, hs_tick} = t;
        step(1);
        {xh_tick, ls_tick, hs_tick} = 3'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic do_reset();
        reset = 1'b1;
        step(16);
        check({usb_osc_en, hs_osc_en, ls_osc_en, usb_clk_on, cpu_run}, 16'h001C);
        reset = 1'b0;
        wait_sig(1'b0, 1'b1, 4);
    endtask
    task automatic test_reset();
        wr_reg(16'hFFA5, 8'h01);
        wr_reg(16'hFFA6, 8'h01);
        wr_reg(16'hFFA7, 8'h80);
        do_reset();
        rd_check(16'hFFA5, 8'h00);
        rd_check(16'hFFA6, 8'h00);
        rd_check(16'hFFA7, 8'h00);
        rd_check(16'hFFA4, 8'h00);
    endtask
    task automatic test_osc_halt();
        wr_reg(16'hFFA6, 8'h01);
        wr_reg(16'hFFA5, 8'hFF);
        step(1);
        check(16'(usb_osc_en), 16'h0000);
        rd_check(16'hFFA5, 8'h01);
        wr_reg(16'hFFA5, 8'h00);
        step(1);
        check(16'(usb_osc_en), 16'h0001);
        step(9200); // 230 us at 25 ns per cycle
        wr_reg(16'hFFA6, 8'h00);
    endtask
    task automatic pll_expect(input int src_mhz, input logic [2:0] pd, input logic [3:0] m);
        step(1);
        check(16'(pll_cfg), {7'h00, 1'b1, hs_sel, pd, m});
        check(16'(src_mhz * pll_cfg.mult / pll_cfg.prediv), 16'h0030);
    endtask
    task automatic test_pll_table();
        wr_reg(16'hFFA6, 8'h00);
        pll_expect(6, ucc_pkg::PLL_PREDIV_1, ucc_pkg::PLL_MULT_X8);
        wr_reg(16'hFFA6, 8'h02);
        step(1);
        check(16'(pll_cfg.run), 16'h0000);
        // switch-over in the documented order: halt, ratio, select, restart
        wr_reg(16'hFFA6, 8'h01);
        step(1);
        check(16'(pll_cfg.run), 16'h0000);
        wr_reg(16'hFFA6, 8'h03);
        hs_sel = 1'b1;
        step(1);
        wr_reg(16'hFFA6, 8'h02);
        pll_expect(16, ucc_pkg::PLL_PREDIV_4, ucc_pkg::PLL_MULT_X12);
        rd_check(16'hFFA6, 8'h02);
        wr_reg(16'hFFA6, 8'h00);
        pll_expect(12, ucc_pkg::PLL_PREDIV_2, ucc_pkg::PLL_MULT_X8);
    endtask
    task automatic test_usb_gate();
        wr_reg(16'hFFA7, 8'hFF);
        wait_sig(1'b1, 1'b1, 16);
        rd_check(16'hFFA7, 8'h80);
        wr_reg(16'hFFA6, 8'h01);
        wait_sig(1'b1, 1'b0, 6);
        wr_reg(16'hFFA6, 8'h00);
        step(12);
        wait_sig(1'b1, 1'b1, 16);
        wr_reg(16'hFFA7, 8'h00);
        step(1);
        check(16'(usb_clk_on), 16'h0000);
    endtask
    task automatic test_ticks();
        pulse(3'b001);
        check({prs_tick, cpu_tick, div_tick[0]}, 16'h0007);
        pulse(3'b010);
        check({prs_tick, cpu_tick, wdt_tick, tmr_tick}, 16'h0003);
        wdt_option = 1'b0;
        pulse(3'b010);
        check({cpu_tick, wdt_tick, tmr_tick}, 16'h0001);
        pulse(3'b100);
        check({prs_tick, cpu_tick}, 16'h0000);
        main_on_hs = 1'b1;
        step(1);
        pulse(3'b100);
        check({prs_tick, cpu_tick}, 16'h0003);
        main_on_hs = 1'b0;
        wdt_option = 1'b1;
    endtask
    // whole periods, so the count does not depend on the divider phase
    task automatic test_prescaler();
        int hits;
        hits = 0;
        div_sel = 3'h1;
        repeat (4) begin
            pulse(3'b001);
            hits += int'(cpu_tick);
        end
        check(16'(hits), 16'h0002);
        hits = 0;
        div_sel = 3'h4;
        repeat (16) begin
            pulse(3'b001);
            hits += int'(cpu_tick);
        end
        check(16'(hits), 16'h0001);
        div_sel = 3'h0;
    endtask
    task automatic test_osc_stop();
        hs_stop_req = 1'b1;
        ls_stop_req = 1'b1;
        step(2);
        check({hs_osc_en, ls_osc_en}, 16'h0003);
        main_on_hs = 1'b1;
        step(2);
        check(16'(hs_osc_en), 16'h0000);
        main_on_hs = 1'b0;
        ls_stoppable = 1'b1;
        step(2);
        check(16'(ls_osc_en), 16'h0000);
        pulse(3'b010);
        check({wdt_tick, tmr_tick}, 16'h0000);
        {hs_stop_req, ls_stop_req} = 2'b00;
    endtask
    task automatic test_ce_freeze();
        ce = 1'b0;
        wr_reg(16'hFFA5, 8'h01);
        check(16'(usb_osc_en), 16'h0001);
        ce = 1'b1;
        rd_check(16'hFFA5, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {reset, wr, rd, hs_sel, main_on_hs, hs_tick, xh_tick, ls_tick} = 8'h80;
        {hs_stop_req, ls_stop_req, ls_stoppable, wdt_option} = 4'h1;
        addr = 16'h0000;
        wdata = 8'h00;
        div_sel = 3'h0;
        ce = 1'b1;
        mismatches = 0;
        n_compared = 0;
        do_reset();
        test_reset();
        test_osc_halt();
        test_pll_table();
        test_usb_gate();
        test_ticks();
        test_prescaler();
        test_osc_stop();
        test_ce_freeze();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        summarize();
    end
endmodule
`default_nettype wire
